// ---- dv/crs_regfile_bench.sv ----
// self-checking bench for the core register set: drives ops, notes expectations
// assumes the src/ package, interface and design modules are compiled first
`default_nettype none
module crs_regfile_bench;
  timeunit 1ns;
  timeprecision 1ps;
  import crs_pkg::*;
  localparam int K_ACC = 0, K_XI = 1, K_YI = 2, K_SPT = 3, K_CNT = 4, K_STA = 5, K_MOD = 6;
  localparam int K_WE = 7, K_PSH = 8, K_WD = 9, K_POP = 10, K_EA = 11, K_ILL = 12;
  localparam int K_IRQ = 13, K_HLT = 14, K_WT = 15, K_MR = 16, K_MWE = 17;
  typedef struct {int id; logic [15:0] v; logic [15:0] m;} crsb_note_t;
  logic clk_i = 1'b0, nrst_i = 1'b0, op_valid_i = 1'b0, irq_req_i = 1'b0, mem_wr_i = 1'b0;
  crs_op_t op_i = nop_op;
  logic [7:0] data_i = 8'h00, mem_wdata_i = 8'h00;
  logic [15:0] operand_i = 16'h0000, mem_addr_i = 16'h0000;
  logic [7:0] acc_o, first_index_o, second_index_o, stack_pointer_o, status_o, core_mode_o;
  logic [7:0] stack_wdata_o, mem_result_o;
  logic [15:0] program_counter_o, push_addr_o, pop_addr_o, eff_addr_o;
  logic stack_we_o, mem_result_we_o, irq_admit_o, illegal_op_o, halted_o, waiting_o;
  crsb_note_t q[$];
  int bad_count = 0, compares = 0, cycles = 0;
  logic [15:0] m_cnt = 16'h0000;
  logic [7:0] m_ps = 8'h04, m_sp = 8'hff;
  logic [31:0] at[3] = '{32'h7f01_8001, 32'h8080_0003, 32'hff01_0002};
  crs_op_t fo[9] = '{raise_carry_op, drop_carry_op, raise_irq_mask_op, drop_irq_mask_op,
    raise_bcd_op, drop_bcd_op, raise_mem_mode_op, drop_mem_mode_op, drop_overflow_op};
  int fb[9] = '{C_BIT, C_BIT, I_BIT, I_BIT, D_BIT, D_BIT, T_BIT, T_BIT, V_BIT};
  int fbit[4] = '{C_BIT, Z_BIT, V_BIT, N_BIT};
  crs_op_t bad[2] = '{fast_set_op, slow_op};
  crs_op_t ho[2] = '{halt_oscillator_op, wait_op};

  crs_regfile dut (.clk_i, .nrst_i, .op_valid_i, .op_i, .data_i, .operand_i, .irq_req_i,
    .mem_wr_i, .mem_addr_i, .mem_wdata_i, .acc_o, .first_index_o, .second_index_o,
    .stack_pointer_o, .program_counter_o, .status_o, .core_mode_o, .stack_we_o, .push_addr_o,
    .stack_wdata_o, .pop_addr_o, .eff_addr_o, .mem_result_o, .mem_result_we_o, .irq_admit_o,
    .illegal_op_o, .halted_o, .waiting_o);

  always #2.5 clk_i = ~clk_i;

  function automatic logic [15:0] view(input int id);
    case (id)
      K_ACC: return {8'h00, acc_o};
      K_XI: return {8'h00, first_index_o};
      K_YI: return {8'h00, second_index_o};
      K_SPT: return {8'h00, stack_pointer_o};
      K_CNT: return program_counter_o;
      K_STA: return {8'h00, status_o};
      K_MOD: return {8'h00, core_mode_o};
      K_WE: return {15'h0000, stack_we_o};
      K_PSH: return push_addr_o;
      K_WD: return {8'h00, stack_wdata_o};
      K_POP: return pop_addr_o;
      K_EA: return eff_addr_o;
      K_ILL: return {15'h0000, illegal_op_o};
      K_IRQ: return {15'h0000, irq_admit_o};
      K_HLT: return {15'h0000, halted_o};
      K_WT: return {15'h0000, waiting_o};
      K_MR: return {8'h00, mem_result_o};
      default: return {15'h0000, mem_result_we_o};
    endcase
  endfunction

  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    compares++;
    if (seen !== exp) begin
      bad_count++;
      $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task automatic note(input int id, input logic [15:0] v, input logic [15:0] m = 16'hffff);
    q.push_back('{id, v, m});
  endtask

  function automatic void nz(input logic [7:0] v);
    m_ps[Z_BIT] = (v == 8'h00);
    m_ps[N_BIT] = v[7];
  endfunction

  // the counter advances on every accepted op except refused ones and branches
  task automatic step(input logic v, input crs_op_t o = nop_op, input logic [7:0] d = 8'h00,
                      input logic [15:0] w = 16'h0000);
    @(negedge clk_i);
    op_valid_i = v;
    op_i = o;
    data_i = d;
    operand_i = w;
    mem_wr_i = 1'b0;
    if (v && !(o inside {fast_set_op, slow_op, branch_op})) m_cnt++;
    note(K_CNT, m_cnt);
  endtask

  task automatic done(input string s);
    $display("test %s done", s);
  endtask

  task automatic report_and_stop();
    $display("compares=%0d bad_count=%0d", compares, bad_count);
    if (bad_count == 0 && compares > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask

  // results land one edge after the op, so every note is due just after the next rise
  always @(posedge clk_i) begin : monitor
    crsb_note_t n;
    #1;
    while (q.size() > 0) begin
      n = q.pop_front();
      check(view(n.id) & n.m, n.v & n.m);
    end
  end

  always @(posedge clk_i) begin
    cycles++;
    if (cycles == 3000) begin
      bad_count++;
      report_and_stop();
    end
  end

  initial begin
    logic [7:0] r;
    logic [15:0] w;
    logic [7:0] ld[3];
    r = 8'($urandom(32'ha59c67cf));
    repeat (4) @(negedge clk_i);
    nrst_i = 1'b1;
    step(1'b0);
    note(K_SPT, 16'h00ff);
    note(K_STA, 16'h0004);
    note(K_PSH, 16'h00ff);
    note(K_POP, 16'h0000);
    done("reset");
    ld = '{8'h00, 8'h80, 8'h01 | (8'($urandom) & 8'h7f)};
    foreach (ld[i]) begin
      step(1'b1, load_acc_op, ld[i]);
      nz(ld[i]);
      note(K_ACC, {8'h00, ld[i]});
      note(K_STA, {8'h00, m_ps});
    end
    for (int k = 0; k < 2; k++) begin
      r = 8'($urandom);
      w = 16'($urandom);
      step(1'b1, k ? load_second_op : load_first_op, r);
      nz(r);
      note(k ? K_YI : K_XI, {8'h00, r}, 16'h00ff);
      step(1'b1, k ? index_second_op : index_first_op, 8'h00, w);
      note(K_EA, w + {8'h00, r});
    end
    done("loads and indexing");
    foreach (fo[i]) begin
      step(1'b1, fo[i]);
      m_ps[fb[i]] = (i % 2 == 0) && (i < 8);
      note(K_STA, {8'h00, m_ps}, 16'h006d);
    end
    done("flag set and clear");
    foreach (at[i]) begin
      step(1'b1, drop_carry_op);
      step(1'b1, load_acc_op, at[i][31:24]);
      step(1'b1, add_with_carry_op, at[i][23:16]);
      nz(at[i][15:8]);
      m_ps[C_BIT] = at[i][1];
      m_ps[V_BIT] = at[i][0];
      note(K_ACC, {8'h00, at[i][15:8]});
      note(K_STA, {8'h00, m_ps});
    end
    for (int f = 0; f < 4; f++) begin
      for (int t = 0; t < 2; t++) begin
        m_cnt = m_cnt + 16'h0001 + ((t == 0) ? 16'hfffe : 16'h0000);
        step(1'b1, branch_op, 8'hfe, {13'h0000, m_ps[fbit[f]] ^ (t == 1), 2'(f)});
      end
    end
    step(1'b1, raise_carry_op);
    step(1'b1, load_acc_op, 8'h80);
    step(1'b1, subtract_with_borrow_op, 8'h01);
    note(K_STA, 16'h0040, 16'h0040);
    step(1'b1, raise_bcd_op);
    step(1'b1, drop_carry_op);
    step(1'b1, load_acc_op, 8'h09);
    step(1'b1, add_with_carry_op, 8'h01);
    note(K_ACC, 16'h0010);
    step(1'b1, drop_bcd_op);
    step(1'b1, mem_test_op, 8'h80);
    note(K_STA, 16'h0080, 16'h00c0);
    step(1'b1, mem_test_op, 8'h40);
    note(K_STA, 16'h0040, 16'h00c0);
    step(1'b1, raise_mem_mode_op);
    step(1'b1, drop_carry_op);
    step(1'b1, add_with_carry_op, 8'h05, 16'h0003);
    note(K_MR, 16'h0008);
    note(K_MWE, 16'h0001);
    note(K_ACC, 16'h0010);
    step(1'b1, drop_mem_mode_op);
    note(K_MWE, 16'h0000);
    done("arithmetic and branches");
    @(negedge clk_i);
    op_valid_i = 1'b0;
    mem_wr_i = 1'b1;
    mem_addr_i = CORE_MODE_ADDR;
    mem_wdata_i = 8'h04;
    note(K_MOD, 16'h0004);
    step(1'b1, load_stack_op, 8'h00);
    m_sp = 8'h00;
    step(1'b1, load_acc_op, 8'h3c);
    step(1'b1, push_acc_op);
    note(K_WE, 16'h0001);
    note(K_PSH, 16'h0100);
    note(K_WD, 16'h003c);
    note(K_SPT, 16'h00ff);
    note(K_POP, 16'h0100);
    step(1'b1, pop_acc_op, 8'h81);
    note(K_ACC, 16'h0081);
    note(K_SPT, 16'h0000);
    note(K_STA, 16'h0080, 16'h0082);
    step(1'b1, push_status_op);
    note(K_WE, 16'h0001);
    note(K_SPT, 16'h00ff);
    step(1'b1, pop_status_op, 8'hff);
    note(K_STA, 16'h00ef);
    step(1'b1, software_break_op);
    note(K_WD, 16'h00ff);
    note(K_STA, 16'h00ef);
    note(K_SPT, 16'h00ff);
    done("stack");
    irq_req_i = 1'b1;
    step(1'b1, drop_irq_mask_op);
    note(K_IRQ, 16'h0001);
    step(1'b1, raise_irq_mask_op);
    note(K_IRQ, 16'h0000);
    irq_req_i = 1'b0;
    foreach (bad[i]) begin
      step(1'b1, bad[i]);
      note(K_ILL, 16'h0001);
    end
    step(1'b1, load_acc_op, 8'h10);
    note(K_ILL, 16'h0000);
    step(1'b1, multiply_op, 8'h10);
    note(K_ACC, 16'h0000);
    note(K_YI, 16'h0001);
    step(1'b1, divide_op, 8'h10);
    note(K_ACC, 16'h0010);
    foreach (ho[i]) begin
      step(1'b1, ho[i]);
      note(i ? K_WT : K_HLT, 16'h0001);
      step(1'b0);
      irq_req_i = 1'b1;
      step(1'b0);
      irq_req_i = 1'b0;
      step(1'b0);
      note(i ? K_WT : K_HLT, 16'h0000);
    end
    done("interrupts and special ops");
    step(1'b0);
    @(negedge clk_i);
    report_and_stop();
  end
endmodule // crs_regfile_bench
`default_nettype wire

// ---- src/crs_alu.sv ----
// binary and decimal add/subtract unit
// assumes operands stable in the cycle they are used; no state of its own
`default_nettype none
module crs_alu (
  crs_alu_if.alu bus
);
  import crs_pkg::*;

  logic [7:0] b_eff;
  logic [8:0] bin_sum;
  logic [4:0] lo_add;
  logic [4:0] hi_add;
  logic [4:0] lo_sub;
  logic [4:0] hi_sub;

  // digit add with correction; bit 4 is the decimal carry
  function automatic logic [4:0] dec_add(input logic [3:0] x, input logic [3:0] y,
                                         input logic c);
    logic [4:0] s;
    s = {1'b0, x} + {1'b0, y} + {4'h0, c};
    if (s > 5'h09) s = s + 5'h06;
    return s;
  endfunction

  // digit subtract; c high means no borrow in, bit 4 is the borrow out
  function automatic logic [4:0] dec_sub(input logic [3:0] x, input logic [3:0] y,
                                         input logic c);
    logic [4:0] d;
    d = {1'b0, x} - {1'b0, y} - {4'h0, ~c};
    if (d[4]) d = d - 5'h06;
    return d;
  endfunction

  assign b_eff = bus.sub ? ~bus.b : bus.b;
  assign bin_sum = {1'b0, bus.a} + {1'b0, b_eff} + {8'h00, bus.cin};
  assign lo_add = dec_add(bus.a[3:0], bus.b[3:0], bus.cin);
  assign hi_add = dec_add(bus.a[7:4], bus.b[7:4], lo_add[4]);
  assign lo_sub = dec_sub(bus.a[3:0], bus.b[3:0], bus.cin);
  assign hi_sub = dec_sub(bus.a[7:4], bus.b[7:4], ~lo_sub[4]);

  assign bus.res = !bus.dec ? bin_sum[7:0] :
                   bus.sub ? {hi_sub[3:0], lo_sub[3:0]} : {hi_add[3:0], lo_add[3:0]};
  assign bus.cout = !bus.dec ? bin_sum[8] : (bus.sub ? ~hi_sub[4] : hi_add[4]);
  // overflow always from the binary sum; not meaningful in decimal mode
  assign bus.ovf = (bus.a[7] == b_eff[7]) && (bin_sum[7] != bus.a[7]);
endmodule // crs_alu
`default_nettype wire

// ---- src/crs_alu_if.sv ----
// adder bundle between the register set and its add/subtract unit
// assumes both ends sit on the same clock; the unit is combinational
`default_nettype none
interface crs_alu_if;
  logic [7:0] a;
  logic [7:0] b;
  logic cin;
  logic sub;
  logic dec;
  logic [7:0] res;
  logic cout;
  logic ovf;
  modport alu (input a, input b, input cin, input sub, input dec,
               output res, output cout, output ovf);
  modport user (output a, output b, output cin, output sub, output dec,
                input res, input cout, input ovf);
endinterface
`default_nettype wire

// ---- src/crs_pkg.sv ----
// shared constants, operation codes and helpers for the core register set
// assumes one 200 MHz core clock and an instruction sequencer outside
`default_nettype none
package crs_pkg;
  localparam int CLK_PERIOD_NS = 5;
  localparam int DATA_W = 8;
  localparam int ADDR_W = 16;

  // status bit positions
  localparam int C_BIT = 0;
  localparam int Z_BIT = 1;
  localparam int I_BIT = 2;
  localparam int D_BIT = 3;
  localparam int B_BIT = 4;
  localparam int T_BIT = 5;
  localparam int V_BIT = 6;
  localparam int N_BIT = 7;

  // reset values
  localparam logic [7:0] ACC_RST = 8'h00;
  localparam logic [7:0] INDEX_RST = 8'h00;
  localparam logic [7:0] STACK_RST = 8'hff;
  localparam logic [15:0] PC_RST = 16'h0000;
  localparam logic [7:0] STATUS_RST = 8'h04;
  localparam logic [7:0] CORE_MODE_RST = 8'h00;

  // core mode register and stack page
  localparam logic [15:0] CORE_MODE_ADDR = 16'h003b;
  localparam int STACK_PAGE_BIT = 2;
  localparam logic [7:0] PAGE0_HI = 8'h00;
  localparam logic [7:0] PAGE1_HI = 8'h01;

  typedef enum logic [5:0] {
    nop_op = 6'b000000, load_acc_op = 6'b000001, load_first_op = 6'b000010,
    load_second_op = 6'b000011, load_stack_op = 6'b000100,
    add_with_carry_op = 6'b000101, subtract_with_borrow_op = 6'b000110,
    shift_left_op = 6'b000111, rotate_left_op = 6'b001000,
    shift_right_op = 6'b001001, rotate_right_op = 6'b001010,
    mem_test_op = 6'b001011, raise_carry_op = 6'b001100,
    drop_carry_op = 6'b001101, raise_irq_mask_op = 6'b001110,
    drop_irq_mask_op = 6'b001111, raise_bcd_op = 6'b010000,
    drop_bcd_op = 6'b010001, raise_mem_mode_op = 6'b010010,
    drop_mem_mode_op = 6'b010011, drop_overflow_op = 6'b010100,
    push_acc_op = 6'b010101, pop_acc_op = 6'b010110,
    push_status_op = 6'b010111, pop_status_op = 6'b011000,
    software_break_op = 6'b011001, irq_entry_op = 6'b011010,
    branch_op = 6'b011011, jump_op = 6'b011100,
    index_first_op = 6'b011101, index_second_op = 6'b011110,
    halt_oscillator_op = 6'b011111, wait_op = 6'b100000,
    multiply_op = 6'b100001, divide_op = 6'b100010,
    fast_set_op = 6'b100011, slow_op = 6'b100100
  } crs_op_t;

  function automatic logic [15:0] crs_stack_addr(input logic page, input logic [7:0] sp);
    return {(page ? PAGE1_HI : PAGE0_HI), sp};
  endfunction

  // zero and negative flags from a result
  function automatic logic [7:0] crs_nz(input logic [7:0] ps, input logic [7:0] v);
    logic [7:0] r;
    r = ps;
    r[Z_BIT] = (v == 8'h00);
    r[N_BIT] = v[7];
    return r;
  endfunction
endpackage
`default_nettype wire

// ---- src/crs_regfile.sv ----
// programmer-visible register set and status flags of an 8-bit core
// assumes an outside sequencer issues one operation per valid cycle and
// returns stack bytes on data_i from pop_addr_o for pops
`default_nettype none
module crs_regfile (
  // clock and reset
  input wire logic clk_i,
  input wire logic nrst_i,
  // operation port
  input wire logic op_valid_i,
  input wire crs_pkg::crs_op_t op_i,
  input wire logic [7:0] data_i,
  input wire logic [15:0] operand_i,
  // interrupt request, same clock domain
  input wire logic irq_req_i,
  // data memory writes seen by the core mode register
  input wire logic mem_wr_i,
  input wire logic [15:0] mem_addr_i,
  input wire logic [7:0] mem_wdata_i,
  // register views
  output logic [7:0] acc_o,
  output logic [7:0] first_index_o,
  output logic [7:0] second_index_o,
  output logic [7:0] stack_pointer_o,
  output logic [15:0] program_counter_o,
  output logic [7:0] status_o,
  output logic [7:0] core_mode_o,
  // stack side
  output logic stack_we_o,
  output logic [15:0] push_addr_o,
  output logic [7:0] stack_wdata_o,
  output logic [15:0] pop_addr_o,
  // addressing and memory results
  output logic [15:0] eff_addr_o,
  output logic [7:0] mem_result_o,
  output logic mem_result_we_o,
  // control
  output logic irq_admit_o,
  output logic illegal_op_o,
  output logic halted_o,
  output logic waiting_o
);
  import crs_pkg::*;

  logic [7:0] accumulator_reg;
  logic [7:0] first_index_reg;
  logic [7:0] second_index_reg;
  logic [7:0] stack_pointer_reg;
  logic [15:0] program_counter_reg;
  logic [7:0] processor_status_reg;
  logic [7:0] core_mode_reg;
  logic halted;
  logic waiting;

  logic [7:0] next_acc, next_first, next_second, next_sp, next_ps;
  logic [15:0] next_pc, next_ea, next_push_addr;
  logic [7:0] next_wdata, next_mem_result;
  logic next_we, next_mem_we, next_illegal, next_halted, next_waiting;
  logic [7:0] next_core_mode;

  logic go;
  logic page;
  logic next_page;
  logic mem_mode;
  logic [15:0] product;
  logic [15:0] quotient;
  logic [15:0] remainder;
  logic branch_flag;
  logic [15:0] branch_target;

  crs_alu_if alu_bus ();
  crs_alu u_alu (.bus(alu_bus.alu));

  // stopped core ignores operations until an interrupt request wakes it
  assign go = op_valid_i & ~halted & ~waiting;
  assign page = core_mode_reg[STACK_PAGE_BIT];
  assign next_page = next_core_mode[STACK_PAGE_BIT];
  assign mem_mode = processor_status_reg[T_BIT];
  assign next_core_mode = (mem_wr_i && mem_addr_i == CORE_MODE_ADDR) ?
                          mem_wdata_i : core_mode_reg;

  // in memory mode the destination byte arrives on operand_i[7:0]
  assign alu_bus.a = mem_mode ? operand_i[7:0] : accumulator_reg;
  assign alu_bus.b = data_i;
  assign alu_bus.cin = processor_status_reg[C_BIT];
  assign alu_bus.sub = (op_i == subtract_with_borrow_op);
  assign alu_bus.dec = processor_status_reg[D_BIT];

  assign product = {8'h00, accumulator_reg} * {8'h00, data_i};
  // divide by zero is caught in the case below before these are used
  assign quotient = {second_index_reg, accumulator_reg} / {8'h00, data_i};
  assign remainder = {second_index_reg, accumulator_reg} % {8'h00, data_i};

  // operand_i[1:0] picks the flag, operand_i[2] the value that takes it
  assign branch_flag = (operand_i[1:0] == 2'b00) ? processor_status_reg[C_BIT] :
                       (operand_i[1:0] == 2'b01) ? processor_status_reg[Z_BIT] :
                       (operand_i[1:0] == 2'b10) ? processor_status_reg[V_BIT] :
                       processor_status_reg[N_BIT];
  assign branch_target = program_counter_reg + 16'h0001 + {{8{data_i[7]}}, data_i};

  always_comb begin
    next_acc = accumulator_reg;
    next_first = first_index_reg;
    next_second = second_index_reg;
    next_sp = stack_pointer_reg;
    next_ps = processor_status_reg;
    next_pc = program_counter_reg;
    next_ea = eff_addr_o;
    next_push_addr = push_addr_o;
    next_wdata = stack_wdata_o;
    next_we = 1'b0;
    next_mem_result = mem_result_o;
    next_mem_we = 1'b0;
    next_illegal = 1'b0;
    next_halted = halted & ~irq_req_i;
    next_waiting = waiting & ~irq_req_i;
    if (go) begin
      next_pc = program_counter_reg + 16'h0001;
      case (op_i)
        load_acc_op: begin
          next_acc = data_i;
          next_ps = crs_nz(processor_status_reg, data_i);
        end
        load_first_op: begin
          next_first = data_i;
          next_ps = crs_nz(processor_status_reg, data_i);
        end
        load_second_op: begin
          next_second = data_i;
          next_ps = crs_nz(processor_status_reg, data_i);
        end
        load_stack_op: next_sp = data_i;
        add_with_carry_op, subtract_with_borrow_op: begin
          if (mem_mode) begin
            next_mem_result = alu_bus.res;
            next_mem_we = 1'b1;
          end else begin
            next_acc = alu_bus.res;
          end
          // decimal results leave only the overflow flag unreliable
          next_ps = crs_nz(processor_status_reg, alu_bus.res);
          next_ps[C_BIT] = alu_bus.cout;
          next_ps[V_BIT] = alu_bus.ovf;
        end
        shift_left_op, rotate_left_op: begin
          next_acc = {accumulator_reg[6:0],
                      (op_i == rotate_left_op) & processor_status_reg[C_BIT]};
          next_ps = crs_nz(processor_status_reg, next_acc);
          next_ps[C_BIT] = accumulator_reg[7];
        end
        shift_right_op, rotate_right_op: begin
          next_acc = {(op_i == rotate_right_op) & processor_status_reg[C_BIT],
                      accumulator_reg[7:1]};
          next_ps = crs_nz(processor_status_reg, next_acc);
          next_ps[C_BIT] = accumulator_reg[0];
        end
        mem_test_op: begin
          next_ps[Z_BIT] = ((accumulator_reg & data_i) == 8'h00);
          next_ps[V_BIT] = data_i[6];
          next_ps[N_BIT] = data_i[7];
        end
        raise_carry_op: next_ps[C_BIT] = 1'b1;
        drop_carry_op: next_ps[C_BIT] = 1'b0;
        raise_irq_mask_op: next_ps[I_BIT] = 1'b1;
        drop_irq_mask_op: next_ps[I_BIT] = 1'b0;
        raise_bcd_op: next_ps[D_BIT] = 1'b1;
        drop_bcd_op: next_ps[D_BIT] = 1'b0;
        raise_mem_mode_op: next_ps[T_BIT] = 1'b1;
        drop_mem_mode_op: next_ps[T_BIT] = 1'b0;
        drop_overflow_op: next_ps[V_BIT] = 1'b0;
        push_acc_op, push_status_op, software_break_op, irq_entry_op: begin
          next_we = 1'b1;
          next_push_addr = crs_stack_addr(page, stack_pointer_reg);
          next_sp = stack_pointer_reg - 8'h01;
          next_wdata = (op_i == push_acc_op) ? accumulator_reg : processor_status_reg;
          if (op_i == software_break_op) begin
            next_wdata[B_BIT] = 1'b1;
          end
          if (op_i == software_break_op || op_i == irq_entry_op) begin
            next_ps[I_BIT] = 1'b1;
          end
        end
        pop_acc_op: begin
          next_sp = stack_pointer_reg + 8'h01;
          next_acc = data_i;
          next_ps = crs_nz(processor_status_reg, data_i);
        end
        pop_status_op: begin
          next_sp = stack_pointer_reg + 8'h01;
          next_ps = data_i;
        end
        branch_op: begin
          if (branch_flag == operand_i[2]) begin
            next_pc = branch_target;
          end
        end
        jump_op: next_pc = operand_i;
        index_first_op: next_ea = operand_i + {8'h00, first_index_reg};
        index_second_op: next_ea = operand_i + {8'h00, second_index_reg};
        halt_oscillator_op: next_halted = 1'b1;
        wait_op: next_waiting = 1'b1;
        multiply_op: begin
          next_acc = product[7:0];
          next_second = product[15:8];
        end
        divide_op: begin
          if (data_i != 8'h00) begin
            next_acc = quotient[7:0];
            next_second = remainder[7:0];
          end
        end
        fast_set_op, slow_op: begin
          next_illegal = 1'b1;
          next_pc = program_counter_reg;
        end
        default: next_ps = processor_status_reg;
      endcase
    end
    next_ps[B_BIT] = 1'b0;
  end

  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      accumulator_reg <= ACC_RST;
      first_index_reg <= INDEX_RST;
      second_index_reg <= INDEX_RST;
      stack_pointer_reg <= STACK_RST;
      program_counter_reg <= PC_RST;
      processor_status_reg <= STATUS_RST;
      core_mode_reg <= CORE_MODE_RST;
    end else begin
      accumulator_reg <= next_acc;
      first_index_reg <= next_first;
      second_index_reg <= next_second;
      stack_pointer_reg <= next_sp;
      program_counter_reg <= next_pc;
      processor_status_reg <= next_ps;
      core_mode_reg <= next_core_mode;
    end
  end

  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      halted <= 1'b0;
      waiting <= 1'b0;
      stack_we_o <= 1'b0;
      push_addr_o <= {PAGE0_HI, STACK_RST};
      stack_wdata_o <= 8'h00;
      pop_addr_o <= {PAGE0_HI, STACK_RST + 8'h01};
      eff_addr_o <= 16'h0000;
      mem_result_o <= 8'h00;
      mem_result_we_o <= 1'b0;
      irq_admit_o <= 1'b0;
      illegal_op_o <= 1'b0;
    end else begin
      halted <= next_halted;
      waiting <= next_waiting;
      stack_we_o <= next_we;
      push_addr_o <= next_push_addr;
      stack_wdata_o <= next_wdata;
      pop_addr_o <= crs_stack_addr(next_page, next_sp + 8'h01);
      eff_addr_o <= next_ea;
      mem_result_o <= next_mem_result;
      mem_result_we_o <= next_mem_we;
      irq_admit_o <= irq_req_i & ~next_ps[I_BIT];
      illegal_op_o <= next_illegal;
    end
  end

  assign acc_o = accumulator_reg;
  assign first_index_o = first_index_reg;
  assign second_index_o = second_index_reg;
  assign stack_pointer_o = stack_pointer_reg;
  assign program_counter_o = program_counter_reg;
  assign status_o = processor_status_reg;
  assign core_mode_o = core_mode_reg;
  assign halted_o = halted;
  assign waiting_o = waiting;

  default clocking @(posedge clk_i); endclocking
  default disable iff (!nrst_i);

  a_break_reads_zero: assert property (status_o[B_BIT] == 1'b0)
    else $error("live break bit not zero");
  a_break_push_flag: assert property (
    go && op_i == software_break_op |=> stack_we_o && stack_wdata_o[B_BIT]
      && status_o[I_BIT]) else $error("break push lacks break bit");
  a_push_page_addr: assert property (
    go && op_i == push_acc_op |=> push_addr_o ==
      {($past(page) ? PAGE1_HI : PAGE0_HI), $past(stack_pointer_reg)})
    else $error("push address wrong page or pointer");
  a_push_ptr_decr: assert property (
    go && op_i == push_status_op |=> stack_pointer_o == $past(stack_pointer_o) - 8'h01)
    else $error("pointer not decremented after push");
  a_pop_acc_load: assert property (
    go && op_i == pop_acc_op |=> acc_o == $past(data_i)
      && stack_pointer_o == $past(stack_pointer_o) + 8'h01)
    else $error("pop did not load accumulator");
  a_irq_masked: assert property (irq_admit_o |-> !status_o[I_BIT] && $past(irq_req_i))
    else $error("interrupt admitted while masked");
  a_illegal_refused: assert property (
    go && (op_i == fast_set_op || op_i == slow_op) |=> illegal_op_o
      && $stable(acc_o) && $stable(program_counter_o))
    else $error("refused op changed state");
  a_mem_test_flags: assert property (
    go && op_i == mem_test_op |=> status_o[7:6] == $past(data_i[7:6]))
    else $error("memory test flags wrong");
  a_index_first_sum: assert property (
    go && op_i == index_first_op |=> eff_addr_o == $past(operand_i) + {8'h00,
      $past(first_index_reg)}) else $error("indexed address wrong");
  a_bin_overflow: assert property (
    go && op_i == add_with_carry_op && !alu_bus.dec && !mem_mode |=>
      status_o[V_BIT] == ($past(acc_o[7]) == $past(data_i[7])
        && acc_o[7] != $past(acc_o[7]))) else $error("overflow flag wrong");
endmodule // crs_regfile
`default_nettype wire
